// file: hw/bwd_pkg.sv
// Shared constants, types and decode helpers for the board watchdog and its controller
package bwd_pkg;

	localparam logic [7:0] WDT_PORT_ADDR = 8'h76;
	localparam logic [7:0] FACTOR_DISABLE = 8'h00;
	localparam logic [7:0] FACTOR_RESET_BASE = 8'h80;
	localparam logic [7:0] FACTOR_INT_BASE = 8'hC0;
	localparam logic [7:0] FACTOR_MODE_MASK = 8'hF8;
	localparam int PERIOD_LSB = 0;
	localparam int PERIOD_W = 3;
	localparam int TICKS_W = 4;
	localparam logic [TICKS_W-1:0] CODE0_TICKS = 4'h1;
	localparam logic [TICKS_W-1:0] UNIT_TICKS = 4'h2;

	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_S = 3;
	localparam int TICK_CYCLES = TICK_S * CLK_HZ;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = BLINK_MS * (CLK_HZ / 1000);
	localparam int RESET_PULSE_US = 2;
	localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * CLK_HZ + 999_999) / 1_000_000;

	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] REG_CMD = 8'h00;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] REG_INT_STAT = 8'h08;
	localparam logic [APB_AW-1:0] REG_INT_MASK = 8'h0C;
	localparam int INT_W = 2;
	localparam int EV_IRQ = 0;
	localparam int EV_RESET = 1;
	localparam int ST_IRQ = 0;
	localparam int ST_RESET = 1;

	typedef enum logic [1:0] {
		WD_OFF = 2'b00,
		WD_COUNT = 2'b01,
		WD_ALERT = 2'b10,
		WD_PULSE = 2'b11
	} bwd_state_type;

	typedef enum logic {
		MODE_RESET = 1'b0,
		MODE_INT = 1'b1
	} bwd_mode_type;

	typedef enum logic [1:0] {
		CMD_IGNORE = 2'b00,
		CMD_DISABLE = 2'b01,
		CMD_ARM_RESET = 2'b10,
		CMD_ARM_INT = 2'b11
	} bwd_cmd_type;

	function automatic bwd_cmd_type bwd_decode(input logic [7:0] factor);
		if (factor == FACTOR_DISABLE)
			return CMD_DISABLE;
		else if ((factor & FACTOR_MODE_MASK) == FACTOR_RESET_BASE)
			return CMD_ARM_RESET;
		else if ((factor & FACTOR_MODE_MASK) == FACTOR_INT_BASE)
			return CMD_ARM_INT;
		else
			return CMD_IGNORE;
	endfunction

	function automatic logic [TICKS_W-1:0] bwd_period_ticks(input logic [PERIOD_W-1:0] code);
		if (code == '0)
			return CODE0_TICKS;
		else
			return TICKS_W'(code) * UNIT_TICKS;
	endfunction

	function automatic logic bwd_mapped(input logic [APB_AW-1:0] addr);
		return (addr == REG_CMD) || (addr == REG_STATUS) || (addr == REG_INT_STAT) || (addr == REG_INT_MASK);
	endfunction

endpackage

// file: hw/bwd_link_if.sv
// I/O write link between host controller and watchdog, with the watchdog's action lines
`timescale 1ns/1ns
interface bwd_link_if;
	logic io_wr;
	logic [7:0] io_addr;
	logic [7:0] io_data;
	logic wdt_irq;
	logic sys_reset;

	modport dev(
		input io_wr,
		input io_addr,
		input io_data,
		output wdt_irq,
		output sys_reset
	);

	modport host(
		output io_wr,
		output io_addr,
		output io_data,
		input wdt_irq,
		input sys_reset
	);
endinterface

// file: hw/bwd_device.sv
// Board watchdog timer: factor register, prescaled time base, expiry actions and status LED
//
// Notes on behaviour
// R01 - Reset leaves watchdog disabled and silent
// R02 - Factor write to port 76H starts counting
// R03 - Factors 80H-87H select reset on expiry
// R04 - Factors C0H-C7H select interrupt on expiry
// R05 - Unit six seconds; code 0 three seconds
// R06 - Valid factor write restarts count from zero, except during the reset pulse or the expiry cycle
// R07 - Expiry gives reset pulse or interrupt
// R08 - LED blinks while enabled, dark otherwise
// R09 - New factor takes effect immediately
// R10 - Writing 00H disables watchdog entirely, except during the reset pulse or the expiry cycle
// R11 - Host rewrites factor within every period
// R12 - Host arms before unmasking interrupt path
// R13 - Prescaled tick; fixed-length reset pulse
`timescale 1ns/1ns
module bwd_device #(
	parameter int TICK_CYCLES = bwd_pkg::TICK_CYCLES,
	parameter int BLINK_CYCLES = bwd_pkg::BLINK_CYCLES,
	parameter int PULSE_CYCLES = bwd_pkg::RESET_PULSE_CYCLES
)(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	bwd_link_if.dev LINK,
	output logic LED_OUT,
	output logic ENABLED_OUT,
	output bwd_pkg::bwd_mode_type MODE_OUT,
	output logic [bwd_pkg::PERIOD_W-1:0] PERIOD_OUT
);
	import bwd_pkg::*;

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam int BW = (BLINK_CYCLES > 1) ? $clog2(BLINK_CYCLES) : 1;
	localparam int PW = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;

	bwd_state_type state_ff;
	bwd_state_type nxt_state;
	bwd_mode_type mode_ff;
	logic [PERIOD_W-1:0] period_ff;
	logic [TW-1:0] presc_ff;
	logic [TICKS_W-1:0] ticks_ff;
	logic [BW-1:0] blink_ff;
	logic [PW-1:0] pulse_ff;
	logic led_ff;
	logic enabled_ff;
	logic irq_ff;
	logic reset_ff;

	logic port_hit;
	bwd_cmd_type cmd;
	logic arm_hit;
	logic off_hit;
	logic tick;
	logic expire;
	logic pulse_done;
	logic restart;

	// Only writes aimed at the watchdog port count; others on the link belong to other devices
	assign port_hit = LINK.io_wr && (LINK.io_addr == WDT_PORT_ADDR); // [R02]
	assign cmd = port_hit ? bwd_decode(LINK.io_data) : CMD_IGNORE;
	assign arm_hit = (cmd == CMD_ARM_RESET) || (cmd == CMD_ARM_INT); // [R03] [R04]
	assign off_hit = (cmd == CMD_DISABLE); // [R10]

	assign tick = (presc_ff == TW'(TICK_CYCLES - 1)); // [R13]
	assign expire = (state_ff == WD_COUNT) && tick
		&& ((ticks_ff + 1'b1) == bwd_period_ticks(period_ff)); // [R05] [R07]
	assign pulse_done = (pulse_ff == PW'(PULSE_CYCLES - 1)); // [R13]

	// Expiry in the same cycle as a trigger wins, so a late trigger cannot hide a time-out
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			WD_OFF:
			begin
				if (arm_hit)
					nxt_state = WD_COUNT; // [R02]
			end
			WD_COUNT:
			begin
				if (expire)
					nxt_state = (mode_ff == MODE_INT) ? WD_ALERT : WD_PULSE; // [R07]
				else if (off_hit)
					nxt_state = WD_OFF; // [R10]
			end
			WD_ALERT:
			begin
				if (off_hit)
					nxt_state = WD_OFF; // [R10]
				else if (arm_hit)
					nxt_state = WD_COUNT; // [R06]
			end
			WD_PULSE:
			begin
				// The board reset that follows clears everything anyway; writes are ignored here
				if (pulse_done)
					nxt_state = WD_OFF;
			end
			default:
			begin
				nxt_state = WD_OFF;
			end
		endcase
	end

	// A trigger restarts the measurement whenever the next state still counts
	assign restart = (nxt_state == WD_COUNT) && ((state_ff != WD_COUNT) || arm_hit); // [R06] [R09]

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			state_ff <= WD_OFF; // [R01]
		else if (CE_IN)
			state_ff <= nxt_state;
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			mode_ff <= MODE_RESET;
			period_ff <= '0;
		end
		else if (CE_IN && restart && arm_hit)
		begin
			mode_ff <= (cmd == CMD_ARM_INT) ? MODE_INT : MODE_RESET; // [R03] [R04] [R09]
			period_ff <= LINK.io_data[PERIOD_LSB +: PERIOD_W]; // [R05] [R09]
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			presc_ff <= '0; // [R01]
		else if (CE_IN)
		begin
			if (restart || (nxt_state != WD_COUNT) || tick)
				presc_ff <= '0; // [R06] [R13]
			else
				presc_ff <= presc_ff + 1'b1;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			ticks_ff <= '0; // [R01]
		else if (CE_IN)
		begin
			if (restart || (nxt_state != WD_COUNT))
				ticks_ff <= '0; // [R06]
			else if (tick)
				ticks_ff <= ticks_ff + 1'b1; // [R05]
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			pulse_ff <= '0;
		else if (CE_IN)
		begin
			if (state_ff == WD_PULSE && !pulse_done)
				pulse_ff <= pulse_ff + 1'b1; // [R13]
			else
				pulse_ff <= '0;
		end
	end

	// Action lines follow the next state so they rise together with it
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			irq_ff <= 1'b0; // [R01]
			reset_ff <= 1'b0; // [R01]
		end
		else if (CE_IN)
		begin
			irq_ff <= (nxt_state == WD_ALERT); // [R07]
			reset_ff <= (nxt_state == WD_PULSE); // [R07]
		end
	end

	// LED blinks through count and alert; a stuck-on LED would look like a live timer
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			blink_ff <= '0;
			led_ff <= 1'b0;
			enabled_ff <= 1'b0;
		end
		else if (CE_IN)
		begin
			enabled_ff <= (nxt_state == WD_COUNT) || (nxt_state == WD_ALERT);
			if ((nxt_state != WD_COUNT) && (nxt_state != WD_ALERT))
			begin
				blink_ff <= '0;
				led_ff <= 1'b0; // [R08]
			end
			else if (blink_ff == BW'(BLINK_CYCLES - 1))
			begin
				blink_ff <= '0;
				led_ff <= !led_ff; // [R08]
			end
			else
			begin
				blink_ff <= blink_ff + 1'b1;
			end
		end
	end

	assign LINK.wdt_irq = irq_ff;
	assign LINK.sys_reset = reset_ff;
	assign LED_OUT = led_ff;
	assign ENABLED_OUT = enabled_ff;
	assign MODE_OUT = mode_ff;
	assign PERIOD_OUT = period_ff;

endmodule

// file: hw/bwd_host.sv
// Host-side controller: APB registers that issue watchdog port writes and report its lines
`timescale 1ns/1ns
module bwd_host (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	bwd_link_if.host LINK,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [bwd_pkg::APB_AW-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	output logic IRQ_OUT
);
	import bwd_pkg::*;

	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic io_wr_ff;
	logic [7:0] io_data_ff;
	logic [7:0] last_factor_ff;
	logic [INT_W-1:0] int_stat_ff;
	logic [INT_W-1:0] int_mask_ff;
	logic [INT_W-1:0] nxt_int_stat;
	logic [INT_W-1:0] events;
	logic irq_prev_ff;
	logic rst_prev_ff;
	logic irq_ff;
	logic access;
	logic done;
	logic wr_done;

	assign access = PSEL_IN && PENABLE_IN;
	assign done = access && pready_ff;
	assign wr_done = done && PWRITE_IN && bwd_mapped(PADDR_IN);

	// One wait state so read data and the answer both leave flip-flops
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end
		else if (CE_IN)
		begin
			pready_ff <= access && !pready_ff;
			pslverr_ff <= access && !pready_ff && !bwd_mapped(PADDR_IN);
			prdata_ff <= '0;
			if (access && !pready_ff && !PWRITE_IN)
			begin
				case (PADDR_IN)
					REG_CMD: prdata_ff <= {24'h000000, last_factor_ff};
					REG_STATUS: prdata_ff <= {30'h00000000, rst_prev_ff, irq_prev_ff};
					REG_INT_STAT: prdata_ff <= {30'h00000000, int_stat_ff};
					REG_INT_MASK: prdata_ff <= {30'h00000000, int_mask_ff};
					default: prdata_ff <= '0;
				endcase
			end
		end
	end

	// Each command write becomes exactly one I/O write cycle to the watchdog port
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			io_wr_ff <= 1'b0;
			io_data_ff <= FACTOR_DISABLE;
			last_factor_ff <= FACTOR_DISABLE;
		end
		else if (CE_IN)
		begin
			io_wr_ff <= wr_done && (PADDR_IN == REG_CMD); // [R02] [R11]
			if (wr_done && (PADDR_IN == REG_CMD))
			begin
				io_data_ff <= PWDATA_IN[7:0]; // [R09] [R10]
				last_factor_ff <= PWDATA_IN[7:0];
			end
		end
	end

	assign events[EV_IRQ] = LINK.wdt_irq && !irq_prev_ff;
	assign events[EV_RESET] = LINK.sys_reset && !rst_prev_ff;

	// New events win over a simultaneous write-one-to-clear
	always_comb
	begin
		nxt_int_stat = int_stat_ff;
		if (wr_done && (PADDR_IN == REG_INT_STAT))
			nxt_int_stat = int_stat_ff & ~PWDATA_IN[INT_W-1:0];
		nxt_int_stat = nxt_int_stat | events;
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			irq_prev_ff <= 1'b0;
			rst_prev_ff <= 1'b0;
			int_stat_ff <= '0;
			int_mask_ff <= '0;
			irq_ff <= 1'b0;
		end
		else if (CE_IN)
		begin
			irq_prev_ff <= LINK.wdt_irq;
			rst_prev_ff <= LINK.sys_reset;
			int_stat_ff <= nxt_int_stat;
			if (wr_done && (PADDR_IN == REG_INT_MASK))
				int_mask_ff <= PWDATA_IN[INT_W-1:0];
			// Mask stays clear until software writes it; unmasking a status bit already set raises the interrupt
			irq_ff <= |(int_stat_ff & int_mask_ff); // [R12]
		end
	end

	assign LINK.io_wr = io_wr_ff;
	assign LINK.io_addr = WDT_PORT_ADDR;
	assign LINK.io_data = io_data_ff;
	assign PRDATA_OUT = prdata_ff;
	assign PREADY_OUT = pready_ff;
	assign PSLVERR_OUT = pslverr_ff;
	assign IRQ_OUT = irq_ff;

endmodule

// file: testbench/bwd_link_asserts.sv
// Checker on the link between watchdog and host controller
`timescale 1ns/1ns
module bwd_link_asserts #(
	parameter int TICK_CYCLES = 20
)(
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	input wire logic io_wr,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_data,
	input wire logic wdt_irq,
	input wire logic sys_reset
);
	import bwd_pkg::*;
	logic wr_ok;
	logic arm;
	logic armed_ff;
	logic mode_ff;
	logic [2:0] code_ff;
	logic [9:0] cnt_ff;
	logic [9:0] lim;
	// Writes during the pulse are dropped by the device
	// Frozen cycles take no write and count no time
	assign wr_ok = CE_IN && io_wr && io_addr == WDT_PORT_ADDR && !sys_reset;
	assign arm = wr_ok && io_data[7] && io_data[5:3] == 3'h0;
	assign lim = code_ff == 3'h0 ? 10'(TICK_CYCLES) : 10'(2 * TICK_CYCLES * code_ff);
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
			armed_ff <= 1'b0;
		else if (arm)
			armed_ff <= 1'b1;
		else if ((wr_ok && io_data == 8'h00) || sys_reset)
			armed_ff <= 1'b0;
	// Saturates so a long idle stretch cannot wrap
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
			cnt_ff <= 10'h000;
		else if (arm)
			cnt_ff <= 10'h000;
		else if (CE_IN && cnt_ff != 10'h3FF)
			cnt_ff <= cnt_ff + 10'h001;
	always_ff @(posedge CLK_IN or negedge RST_N_IN)
		if (!RST_N_IN)
			{mode_ff, code_ff} <= 4'h0;
		else if (arm)
			{mode_ff, code_ff} <= {io_data[6], io_data[2:0]};
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	sequence pulse_s;
		sys_reset [*4] ##1 !sys_reset;
	endsequence
	sequence quiet_s;
		(!sys_reset && !wdt_irq) [*8];
	endsequence
	pulse_len_a: assert property ($rose(sys_reset) |-> pulse_s)
		else $error("reset pulse length wrong");
	reset_time_a: assert property ($rose(sys_reset) |-> armed_ff && !mode_ff && cnt_ff >= lim && cnt_ff <= lim + 10'h002)
		else $error("reset pulse at wrong time");
	irq_time_a: assert property ($rose(wdt_irq) |-> armed_ff && mode_ff && cnt_ff >= lim && cnt_ff <= lim + 10'h002)
		else $error("interrupt at wrong time");
	restart_quiet_a: assert property (arm |-> ##3 quiet_s)
		else $error("action right after restart");
	off_quiet_a: assert property (wr_ok && io_data == 8'h00 |-> ##3 quiet_s)
		else $error("action after disable");
	one_action_a: assert property (!(wdt_irq && sys_reset))
		else $error("both actions at once");
	boot_quiet_a: assert property ($rose(RST_N_IN) |-> quiet_s)
		else $error("action after reset");
	port_addr_a: assert property (io_wr |-> io_addr == WDT_PORT_ADDR)
		else $error("write to wrong port");
endmodule

// file: testbench/board_watchdog_timer_bench.sv
// Bench for the watchdog with its APB host controller
`timescale 1ns/1ns
module board_watchdog_timer_bench;
	import bwd_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, perr, erd, irq, led, en, b;
	logic [2:0] per;
	bwd_mode_type mode;
	int n_fail = 0;
	int checked = 0;
	bwd_link_if link();
	bwd_device #(.TICK_CYCLES(20), .BLINK_CYCLES(4), .PULSE_CYCLES(4)) bwd_device_i(.CLK_IN(clk), .RST_N_IN(rst_n),
		.CE_IN(ce), .LINK(link), .LED_OUT(led), .ENABLED_OUT(en), .MODE_OUT(mode), .PERIOD_OUT(per));
	bwd_host bwd_host_i(.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .LINK(link), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .IRQ_OUT(irq));
	bwd_link_asserts #(.TICK_CYCLES(20)) bwd_link_asserts_i(.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.io_wr(link.io_wr), .io_addr(link.io_addr), .io_data(link.io_data), .wdt_irq(link.wdt_irq),
		.sys_reset(link.sys_reset));
	initial forever #10 clk = ~clk;
	task automatic stop_test();
		$display("checked %0d failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		erd = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// A slave that never answers is a failure, not a pass
		if (pready !== 1'b1)
		begin
			n_fail++;
			$display("[ERR] apb ready exp 1 got %b", pready);
			stop_test();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("register", e, rd);
	endtask
	// Skips the first cycles so a line still high from before has dropped
	task automatic expire(input logic i, input int e);
		int n;
		n = 4;
		repeat (4) @(posedge clk);
		while ((i ? link.wdt_irq : link.sys_reset) !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		chk("expiry time", 1'b1, n >= e && n <= e + 4);
		if ((i ? link.wdt_irq : link.sys_reset) !== 1'b1)
		begin
			n_fail++;
			$display("[ERR] expiry line exp 1 got %b", i ? link.wdt_irq : link.sys_reset);
			stop_test();
		end
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk("enabled", 1'b0, en);
		rdchk(REG_STATUS, 32'h0);
		rdchk(REG_INT_MASK, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 1'b1, erd);
		$display("test reset done");
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, REG_CMD, 32'h80 + c);
			repeat (3) @(posedge clk);
			chk("mode", MODE_RESET, mode);
			chk("period", c, per);
			chk("enabled", 1'b1, en);
		end
		b = led;
		repeat (4) @(posedge clk);
		chk("led", !b, led);
		repeat (3)
		begin
			apb(1'b1, REG_CMD, 32'h81);
			repeat (30) @(posedge clk);
		end
		apb(1'b1, REG_CMD, 32'h81);
		expire(1'b0, 40);
		repeat (6) @(posedge clk);
		chk("enabled", 1'b0, en);
		$display("test reset mode done");
		for (int c = 0; c < 8; c++)
		begin
			apb(1'b1, REG_CMD, 32'hC0 + c);
			expire(1'b1, c ? 40 * c : 20);
			chk("mode", MODE_INT, mode);
		end
		rdchk(REG_STATUS, 32'h1);
		apb(1'b1, REG_CMD, 32'h0);
		repeat (4) @(posedge clk);
		chk("irq line", 1'b0, link.wdt_irq);
		chk("led", 1'b0, led);
		apb(1'b1, REG_CMD, 32'h81);
		repeat (10) @(posedge clk);
		apb(1'b1, REG_CMD, 32'h55);
		repeat (3) @(posedge clk);
		chk("period", 3'h1, per);
		rdchk(REG_CMD, 32'h55);
		apb(1'b1, REG_CMD, 32'hC2);
		expire(1'b1, 80);
		$display("test interrupt mode done");
		rdchk(REG_INT_STAT, 32'h3);
		chk("irq", 1'b0, irq);
		apb(1'b1, REG_INT_MASK, 32'h3);
		rdchk(REG_INT_MASK, 32'h3);
		chk("irq", 1'b1, irq);
		apb(1'b1, REG_INT_STAT, 32'h1);
		rdchk(REG_INT_STAT, 32'h2);
		apb(1'b1, REG_INT_MASK, 32'h1);
		repeat (3) @(posedge clk);
		chk("irq", 1'b0, irq);
		apb(1'b1, REG_CMD, 32'h80);
		apb(1'b1, REG_CMD, 32'h0);
		repeat (60) @(posedge clk);
		rdchk(REG_INT_STAT, 32'h2);
		$display("test status done");
		// Twenty frozen cycles push a 40-cycle expiry out by twenty
		apb(1'b1, REG_CMD, 32'hC1);
		repeat (10) @(posedge clk);
		ce <= 1'b0;
		@(posedge clk);
		b = led;
		repeat (19) @(posedge clk);
		chk("led frozen", b, led);
		chk("irq line", 1'b0, link.wdt_irq);
		ce <= 1'b1;
		expire(1'b1, 30);
		repeat (4) @(posedge clk);
		chk("irq", 1'b1, irq);
		$display("test freeze done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk("enabled", 1'b0, en);
		chk("irq line", 1'b0, link.wdt_irq);
		chk("irq", 1'b0, irq);
		rdchk(REG_INT_STAT, 32'h0);
		rdchk(REG_INT_MASK, 32'h0);
		$display("test second reset done");
		stop_test();
	end
endmodule
